// ==== rtl/cpu_bus_cycle_sequencer.sv ====
// Purpose: per-cycle bus sequencing for one instruction or interrupt entry
// Assumes: decoder supplies mode, class and register values at start
// Notes:   ALU and register updates live elsewhere
// Function
// [RULE1] Immediate: 8-bit op 2 cycles, 16-bit 3 cycles, high byte first.
// [RULE2] Direct: address byte in cycle 2; 8-bit read 3, 16-bit 4 cycles.
// [RULE3] Direct stores 4 or 5 cycles; cycle 3 strobe low, then writes high-low.
// [RULE4] Strobe-low cycles hold read/write at read and ignore data.
// [RULE5] Indexed: index in cycle 3, index plus offset no carry in 4; jump ends.
// [RULE6] Indexed read 5 cycles; 16-bit read 6, low byte at address plus one.
// [RULE7] Indexed read-modify-write 7 cycles: read, idle, write same address.
// [RULE8] Indexed call 8 cycles: push low, high, then three strobe-low cycles.
// [RULE9] Extended jump 3 cycles reading target high then low byte.
// [RULE10] Extended: address high then low; 8-bit read 4 cycles.
// [RULE11] Extended 16-bit load or compare 5 cycles, high then low byte.
// [RULE12] Interrupt entry 12 cycles, or 4 cycles after wait-for-interrupt.
// [RULE13] Test-only variant drives strobe low in last cycle, no write.
// [RULE14] Memory floats data bus while strobe is low.
// [RULE15] First cycle reads opcode at program counter, strobe high, read.
// [RULE16] Devices respond only while strobe high; capture data on write.
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer
   import seq_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Instruction request
   input  wire logic        start,
   input  wire logic [2:0]  mode,
   input  wire logic [2:0]  op_class,
   input  wire logic        irq_start,
   input  wire logic        wait_for_interrupt,
   input  wire logic [15:0] pc,
   input  wire logic [15:0] index_reg,
   input  wire logic [15:0] stack_ptr,
   input  wire logic [15:0] wr_data,
   // Bus
   input  wire logic [7:0]  data_in,
   output logic [15:0]      addr_q,
   output logic             memory_valid_strobe_q,
   output logic             read_not_write_q,
   output logic [7:0]       data_out_q,
   output logic             data_oe_n_q,
   // Status
   output logic             busy_q,
   output logic             done_q,
   output logic [7:0]       rd_data_q,
   output logic             rd_valid_q
);
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} state_e;
   state_e      state_q;
   logic [3:0]  cyc_q;
   logic [3:0]  last_q;
   logic [2:0]  mode_q;
   logic [2:0]  cls_q;
   logic        irq_q;
   logic [15:0] pc_q, ix_q, sp_q, wd_q, ea_q;
   logic [7:0]  b2_q;
   // Per-cycle decoded drive
   logic [15:0] a_d;
   logic        v_d, r_d, cap_d;
   logic [7:0]  w_d;
   // Operand address as seen in the cycle that needs it, and call return address
   logic [15:0] ea_w;
   logic [15:0] ret_w;
   assign ea_w  = (cyc_q == 4'h3 && mode_q == MODE_DIR) ? {8'h00, data_in} :
                  (cyc_q == 4'h4 && mode_q == MODE_EXT) ? {b2_q, data_in} : ea_q;
   assign ret_w = pc_q + 16'h0002;

   // ----------------------------------------
   // Cycle count per mode and class
   // ----------------------------------------
   function automatic logic [3:0] cycles(input logic [2:0] m, input logic [2:0] c);
      logic [3:0] n;
      n = 4'h2;
      case (m)
         MODE_IMM: n = (c == OP_READ16) ? 4'h3 : 4'h2; // RULE1
         MODE_DIR: begin
            case (c)
               OP_READ16:  n = 4'h4; // RULE2
               OP_STORE8:  n = 4'h4; // RULE3
               OP_STORE16: n = 4'h5; // RULE3
               default:    n = 4'h3; // RULE2
            endcase
         end
         MODE_IDX: begin
            case (c)
               OP_JUMP:    n = 4'h4; // RULE5
               OP_READ16:  n = 4'h6; // RULE6
               OP_STORE8:  n = 4'h6;
               OP_STORE16: n = 4'h7;
               OP_RMW:     n = 4'h7; // RULE7
               OP_TEST:    n = 4'h7; // RULE7
               OP_CALL:    n = 4'h8; // RULE8
               default:    n = 4'h5; // RULE6
            endcase
         end
         MODE_EXT: begin
            case (c)
               OP_JUMP:    n = 4'h3; // RULE9
               OP_READ16:  n = 4'h5; // RULE11
               OP_STORE8:  n = 4'h5;
               OP_STORE16: n = 4'h6;
               OP_RMW:     n = 4'h6;
               OP_TEST:    n = 4'h6;
               OP_CALL:    n = 4'h9;
               default:    n = 4'h4; // RULE10
            endcase
         end
         default: n = 4'h2;
      endcase
      return n;
   endfunction

   // ----------------------------------------
   // Sequencing state
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         cyc_q   <= 4'h0;
         last_q  <= 4'h0;
         mode_q  <= 3'h0;
         cls_q   <= 3'h0;
         irq_q   <= 1'b0;
         pc_q    <= 16'h0000;
         ix_q    <= 16'h0000;
         sp_q    <= 16'h0000;
         wd_q    <= 16'h0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (irq_start || start) begin
                  state_q <= ST_RUN;
                  cyc_q   <= 4'h1;
                  irq_q   <= irq_start;
                  mode_q  <= mode;
                  cls_q   <= op_class;
                  pc_q    <= pc;
                  ix_q    <= index_reg;
                  sp_q    <= stack_ptr;
                  wd_q    <= wr_data;
                  if (irq_start) begin
                     last_q <= wait_for_interrupt ? IRQ_WAIT_CYCLES : IRQ_CYCLES; // RULE12
                  end else begin
                     last_q <= cycles(mode, op_class);
                  end
               end
            end
            ST_RUN: begin
               if (cyc_q == last_q) begin
                  state_q <= ST_IDLE;
               end else begin
                  cyc_q <= cyc_q + 4'h1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Operand address bytes captured from the bus
   // Outputs are registered, so a byte arrives one sequencer cycle after its address
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         b2_q <= 8'h00;
         ea_q <= 16'h0000;
      end else if (state_q == ST_RUN && !irq_q) begin
         if (cyc_q == 4'h3) begin
            b2_q <= data_in;
            if (mode_q == MODE_DIR) begin
               ea_q <= {8'h00, data_in}; // RULE2
            end
            if (mode_q == MODE_IDX) begin
               ea_q <= ix_q + {8'h00, data_in};
            end
         end
         if (cyc_q == 4'h4 && mode_q == MODE_EXT) begin
            ea_q <= {b2_q, data_in}; // RULE10
         end
      end
   end

   // ----------------------------------------
   // Per-cycle bus decode
   // ----------------------------------------
   always_comb begin
      a_d   = pc_q;
      v_d   = 1'b1;
      r_d   = 1'b1;
      w_d   = 8'h00;
      cap_d = 1'b0;
      if (cyc_q == 4'h1 && !irq_q) begin
         a_d = pc_q; // RULE15
      end else if (irq_q) begin
         // Interrupt entry stacks registers; write during push cycles
         a_d = sp_q - {12'h000, cyc_q};
         v_d = (last_q == IRQ_WAIT_CYCLES) ? 1'b1 : (cyc_q != 4'hA);
         r_d = !(last_q == IRQ_CYCLES && cyc_q >= 4'h3 && cyc_q <= 4'h9);
         if (cyc_q == 4'hB || (last_q == IRQ_WAIT_CYCLES && cyc_q == 4'h3)) begin
            a_d = 16'hFFFA;
         end
         if (cyc_q == 4'hC || (last_q == IRQ_WAIT_CYCLES && cyc_q == 4'h4)) begin
            a_d = 16'hFFFB;
         end
      end else if (cyc_q == 4'h2) begin
         a_d = pc_q + 16'h0001; // RULE1
         cap_d = (mode_q == MODE_IMM);
      end else begin
         case (mode_q)
            MODE_IMM: begin
               a_d   = pc_q + 16'h0002; // RULE1
               cap_d = 1'b1;
            end
            MODE_EXT: begin
               if (cyc_q == 4'h3) begin
                  a_d = pc_q + 16'h0002; // RULE9
               end else begin
                  a_d   = (cyc_q == 4'h4) ? ea_w : ea_q + 16'h0001; // RULE11
                  cap_d = 1'b1;
               end
            end
            MODE_DIR: begin
               if (cls_q == OP_STORE8 || cls_q == OP_STORE16) begin
                  a_d = (cyc_q == 4'h5) ? ea_q + 16'h0001 : ea_w;
                  v_d = (cyc_q != 4'h3); // RULE3
                  r_d = (cyc_q == 4'h3);
                  w_d = (cyc_q == 4'h5 || cls_q == OP_STORE8) ? wd_q[7:0] : wd_q[15:8];
               end else begin
                  a_d   = (cyc_q == 4'h4) ? ea_q + 16'h0001 : ea_w; // RULE2
                  cap_d = 1'b1;
               end
            end
            default: begin
               if (cls_q == OP_CALL) begin
                  case (cyc_q)
                     4'h3: begin a_d = ix_q; v_d = 1'b0; end
                     4'h4: begin a_d = sp_q; r_d = 1'b0; w_d = ret_w[7:0]; end // RULE8
                     4'h5: begin a_d = sp_q - 16'h0001; r_d = 1'b0; w_d = ret_w[15:8]; end
                     4'h6: begin a_d = sp_q - 16'h0002; v_d = 1'b0; end // RULE8
                     4'h7: begin a_d = ix_q; v_d = 1'b0; end
                     default: begin a_d = {ix_q[15:8], ea_q[7:0]}; v_d = 1'b0; end
                  endcase
               end else if (cyc_q == 4'h3) begin
                  a_d = ix_q; // RULE5
                  v_d = 1'b0;
               end else if (cyc_q == 4'h4) begin
                  a_d = {ix_q[15:8], ea_q[7:0]}; // RULE5
                  v_d = 1'b0;
               end else begin
                  a_d = (cyc_q == 4'h6 && cls_q == OP_READ16) ? ea_q + 16'h0001 : ea_q; // RULE6
                  a_d = (cyc_q == 4'h7 && cls_q == OP_STORE16) ? ea_q + 16'h0001 : a_d;
                  cap_d = (cls_q == OP_READ8 || cls_q == OP_READ16 ||
                           ((cls_q == OP_RMW || cls_q == OP_TEST) && cyc_q == 4'h5));
                  if (cls_q == OP_RMW || cls_q == OP_TEST) begin
                     v_d = (cyc_q == 4'h5) || (cyc_q == 4'h7 && cls_q == OP_RMW); // RULE7 RULE13
                     r_d = !(cyc_q == 4'h7 && cls_q == OP_RMW);
                     w_d = wd_q[7:0];
                  end else if (cls_q == OP_STORE8 || cls_q == OP_STORE16) begin
                     v_d = (cyc_q != 4'h5);
                     r_d = (cyc_q == 4'h5);
                     w_d = (cyc_q == 4'h7 || cls_q == OP_STORE8) ? wd_q[7:0] : wd_q[15:8];
                  end
               end
            end
         endcase
      end
      if (!v_d) begin
         r_d   = 1'b1; // RULE4
         cap_d = 1'b0;
      end
   end

   // ----------------------------------------
   // Registered bus outputs
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_q                <= 16'h0000;
         memory_valid_strobe_q <= 1'b0;
         read_not_write_q      <= 1'b1;
         data_out_q            <= 8'h00;
         data_oe_n_q           <= 1'b1;
         busy_q                <= 1'b0;
         done_q                <= 1'b0;
      end else begin
         // Outputs lag the sequencer by one cycle for flop-only outputs
         addr_q                <= (state_q == ST_RUN) ? a_d : addr_q;
         memory_valid_strobe_q <= (state_q == ST_RUN) && v_d;
         read_not_write_q      <= (state_q != ST_RUN) || r_d;
         data_out_q            <= w_d;
         data_oe_n_q           <= !((state_q == ST_RUN) && !r_d); // RULE16
         busy_q                <= (state_q == ST_RUN);
         done_q                <= (state_q == ST_RUN) && (cyc_q == last_q);
      end
   end

   // Read data capture, only on strobe-high read cycles
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= memory_valid_strobe_q && read_not_write_q && busy_q; // RULE4 RULE14
         if (memory_valid_strobe_q && read_not_write_q) begin
            rd_data_q <= data_in;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_IDLE_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
      !memory_valid_strobe_q |-> read_not_write_q) else $error("write with strobe low"); // RULE4
   AST_IRQ_LEN: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state_q == ST_IDLE && irq_start && !start && !wait_for_interrupt) |=> ##11 (cyc_q == 4'hC))
      else $error("interrupt entry length wrong"); // RULE12
   AST_OPCODE_FETCH: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state_q == ST_RUN && cyc_q == 4'h1 && !irq_q) |=> memory_valid_strobe_q && read_not_write_q)
      else $error("opcode fetch not a read"); // RULE15
   AST_DIR_STORE_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE3
      (state_q == ST_RUN && !irq_q && mode_q == MODE_DIR && cls_q == OP_STORE8 && cyc_q == 4'h4)
      |=> memory_valid_strobe_q && !read_not_write_q) else $error("direct store not a write");
   AST_IDX_STROBE_LOW: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE5
      (state_q == ST_RUN && !irq_q && mode_q == MODE_IDX && cyc_q == 4'h3)
      |=> !memory_valid_strobe_q) else $error("indexed cycle 3 strobe high");
   AST_TEST_NO_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
      (state_q == ST_RUN && !irq_q && mode_q == MODE_IDX && cls_q == OP_TEST && cyc_q == 4'h7)
      |=> !memory_valid_strobe_q && read_not_write_q) else $error("test-only last cycle wrote");
endmodule

// ==== rtl/seq_pkg.sv ====
// Purpose: constants for the bus-cycle sequencer
// Assumes: one bus cycle per core_clk cycle
// Notes:   addressing mode and class codes, interrupt entry cycle counts
package seq_pkg;
   // ----------------------------------------
   // Addressing modes
   // ----------------------------------------
   localparam logic [2:0] MODE_IMM  = 3'h0;
   localparam logic [2:0] MODE_DIR  = 3'h1;
   localparam logic [2:0] MODE_IDX  = 3'h2;
   localparam logic [2:0] MODE_EXT  = 3'h3;
   // ----------------------------------------
   // Operation classes
   // ----------------------------------------
   localparam logic [2:0] OP_READ8  = 3'h0;
   localparam logic [2:0] OP_READ16 = 3'h1;
   localparam logic [2:0] OP_STORE8 = 3'h2;
   localparam logic [2:0] OP_STORE16= 3'h3;
   localparam logic [2:0] OP_RMW    = 3'h4;
   localparam logic [2:0] OP_TEST   = 3'h5;
   localparam logic [2:0] OP_JUMP   = 3'h6;
   localparam logic [2:0] OP_CALL   = 3'h7;
   // ----------------------------------------
   // Interrupt entry lengths and reset stack pointer low byte
   // ----------------------------------------
   localparam logic [3:0] IRQ_CYCLES      = 4'hC;
   localparam logic [3:0] IRQ_WAIT_CYCLES = 4'h4;
   localparam logic [7:0] RESET_SP_LOW    = 8'hFF;
endpackage

// ==== verification/bus_mem_model.sv ====
// Purpose: memory and peripheral stand-in on the far side of the parallel bus
// Assumes: combinational read answer to the registered bus outputs
// Notes:   released data bus toggles so a stale value never passes as a read
`timescale 1ns/1ps
module bus_mem_model (
   // Clock
   input  wire logic        core_clk,
   // Bus from the sequencer
   input  wire logic [15:0] addr,
   input  wire logic        strobe,
   input  wire logic        rnw,
   input  wire logic [7:0]  wdata,
   input  wire logic        oe_n,
   // Read data and last captured write
   output logic      [7:0]  rdata,
   output logic      [15:0] wr_addr_q,
   output logic      [7:0]  wr_byte_q
);
   logic [7:0] last_q = 8'h00;
   always_comb begin
      if (strobe && rnw) begin
         rdata = addr[7:0] ^ addr[15:8] ^ 8'h3C;
      end else begin
         rdata = ~last_q;
      end
   end
   always_ff @(posedge core_clk) begin
      last_q <= rdata;
      if (strobe && !rnw && !oe_n) begin
         wr_addr_q <= addr;
         wr_byte_q <= wdata;
      end
   end
endmodule

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the bus-cycle sequencer
// Assumes: bus cycle 1 found by opcode fetch, later cycles one per clock
// Notes:   interrupt lengths judged relative to a 2-cycle instruction
`timescale 1ns/1ps
module tb;
   import seq_pkg::*;
   logic        core_clk, sys_rst, start, irq_start, wait_for_interrupt;
   logic [2:0]  mode, op_class;
   logic [15:0] pc, index_reg, stack_ptr, wr_data, addr_q, wr_addr_q;
   logic [7:0]  data_in, data_out_q, rd_data_q, wr_byte_q;
   logic        memory_valid_strobe_q, read_not_write_q, data_oe_n_q;
   logic        busy_q, done_q, rd_valid_q;
   logic [15:0] e_a [1:8];
   logic        e_s [1:8];
   logic        e_r [1:8];
   logic [8:0]  e_d [1:8];
   logic [15:0] da, nc, eff, ea;
   int          err_total, n_tests, n0, n1, n2;

   cpu_bus_cycle_sequencer dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .start(start),
      .mode(mode), .op_class(op_class), .irq_start(irq_start),
      .wait_for_interrupt(wait_for_interrupt), .pc(pc), .index_reg(index_reg),
      .stack_ptr(stack_ptr), .wr_data(wr_data), .data_in(data_in), .addr_q(addr_q),
      .memory_valid_strobe_q(memory_valid_strobe_q), .read_not_write_q(read_not_write_q),
      .data_out_q(data_out_q), .data_oe_n_q(data_oe_n_q), .busy_q(busy_q),
      .done_q(done_q), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
   bus_mem_model mem_u (.core_clk(core_clk), .addr(addr_q), .strobe(memory_valid_strobe_q),
      .rnw(read_not_write_q), .wdata(data_out_q), .oe_n(data_oe_n_q), .rdata(data_in),
      .wr_addr_q(wr_addr_q), .wr_byte_q(wr_byte_q));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] mb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (e !== s) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic ex(input int i, input logic [15:0] a, input logic s, input logic r,
                     input logic [8:0] d);
      e_a[i] = a;
      e_s[i] = s;
      e_r[i] = r;
      e_d[i] = d;
   endtask
   task automatic settle();
      int k;
      k = 0;
      while (busy_q !== 1'b0 && k < 12) begin
         @(negedge core_clk);
         k++;
      end
      chk("idle", 16'h0, 16'(k == 12));
   endtask
   task automatic run(input logic [2:0] m, input logic [2:0] op, input int n);
      int k;
      ex(1, pc, 1'b1, 1'b1, 9'h0);
      ex(2, pc + 16'h1, 1'b1, 1'b1, 9'h0);
      @(negedge core_clk);
      start = 1'b1;
      mode = m;
      op_class = op;
      @(negedge core_clk);
      start = 1'b0;
      k = 0;
      while (!(memory_valid_strobe_q === 1'b1 && addr_q === pc) && k < 4) begin
         @(negedge core_clk);
         k++;
      end
      for (int i = 1; i <= n; i++) begin
         chk("addr", e_a[i], addr_q);
         chk("strobe", 16'(e_s[i]), 16'(memory_valid_strobe_q));
         chk("rnw", 16'(e_r[i]), 16'(read_not_write_q));
         chk("done", 16'(i == n), 16'(done_q));
         if (e_d[i][8]) chk("wdata", 16'(e_d[i][7:0]), 16'(data_out_q));
         if (!e_s[i]) chk("oe_n", 16'h1, 16'(data_oe_n_q));
         if (i < n) @(negedge core_clk);
      end
      settle();
   endtask
   task automatic lat(input logic irq, input logic w, output int n);
      @(negedge core_clk);
      start = !irq;
      irq_start = irq;
      wait_for_interrupt = w;
      mode = MODE_IMM;
      op_class = OP_READ8;
      @(negedge core_clk);
      start = 1'b0;
      irq_start = 1'b0;
      n = 1;
      while (done_q !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      settle();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_imm_dir();
      ex(3, pc + 16'h2, 1'b1, 1'b1, 9'h0);
      run(MODE_IMM, OP_READ8, 2);
      run(MODE_IMM, OP_READ16, 3);
      ex(3, da, 1'b1, 1'b1, 9'h0);
      run(MODE_DIR, OP_READ8, 3);
      chk("rd_data", 16'(mb(da)), 16'(rd_data_q));
      ex(4, da + 16'h1, 1'b1, 1'b1, 9'h0);
      run(MODE_DIR, OP_READ16, 4);
   endtask
   task automatic t_dir_store();
      ex(3, da, 1'b0, 1'b1, 9'h0);
      ex(4, da, 1'b1, 1'b0, {1'b1, wr_data[7:0]});
      run(MODE_DIR, OP_STORE8, 4);
      ex(4, da, 1'b1, 1'b0, {1'b1, wr_data[15:8]});
      ex(5, da + 16'h1, 1'b1, 1'b0, {1'b1, wr_data[7:0]});
      run(MODE_DIR, OP_STORE16, 5);
      chk("wr_addr", da + 16'h1, wr_addr_q);
   endtask
   task automatic t_idx();
      // Offset chosen so the low-byte sum carries
      ex(3, index_reg, 1'b0, 1'b1, 9'h0);
      ex(4, nc, 1'b0, 1'b1, 9'h0);
      run(MODE_IDX, OP_JUMP, 4);
      ex(5, eff, 1'b1, 1'b1, 9'h0);
      run(MODE_IDX, OP_READ8, 5);
      ex(6, eff + 16'h1, 1'b1, 1'b1, 9'h0);
      run(MODE_IDX, OP_READ16, 6);
      ex(6, eff, 1'b0, 1'b1, 9'h0);
      ex(7, eff, 1'b1, 1'b0, 9'h0);
      run(MODE_IDX, OP_RMW, 7);
      ex(7, eff, 1'b0, 1'b1, 9'h0);
      run(MODE_IDX, OP_TEST, 7);
   endtask
   task automatic t_call();
      logic [15:0] ret;
      ret = pc + 16'h2;
      ex(4, stack_ptr, 1'b1, 1'b0, {1'b1, ret[7:0]});
      ex(5, stack_ptr - 16'h1, 1'b1, 1'b0, {1'b1, ret[15:8]});
      ex(6, stack_ptr - 16'h2, 1'b0, 1'b1, 9'h0);
      ex(7, index_reg, 1'b0, 1'b1, 9'h0);
      ex(8, nc, 1'b0, 1'b1, 9'h0);
      run(MODE_IDX, OP_CALL, 8);
   endtask
   task automatic t_ext();
      ex(3, pc + 16'h2, 1'b1, 1'b1, 9'h0);
      run(MODE_EXT, OP_JUMP, 3);
      ex(4, ea, 1'b1, 1'b1, 9'h0);
      run(MODE_EXT, OP_READ8, 4);
      ex(5, ea + 16'h1, 1'b1, 1'b1, 9'h0);
      run(MODE_EXT, OP_READ16, 5);
   endtask
   task automatic t_irq();
      lat(1'b0, 1'b0, n0);
      lat(1'b1, 1'b0, n1);
      lat(1'b1, 1'b1, n2);
      chk("irq_len", 16'(IRQ_CYCLES) - 16'h2, 16'(n1 - n0));
      chk("wait_len", 16'(IRQ_WAIT_CYCLES) - 16'h2, 16'(n2 - n0));
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      final_report();
   end
   initial begin
      {start, irq_start, wait_for_interrupt, mode, op_class} = '0;
      sys_rst = 1'b1;
      pc = 16'h12F0;
      index_reg = 16'h20F8;
      stack_ptr = 16'h01FF;
      wr_data = 16'hA55A;
      err_total = 0;
      n_tests = 0;
      da = {8'h00, mb(pc + 16'h1)};
      nc = {index_reg[15:8], index_reg[7:0] + mb(pc + 16'h1)};
      eff = index_reg + 16'(mb(pc + 16'h1));
      ea = {mb(pc + 16'h1), mb(pc + 16'h2)};
      repeat (4) @(negedge core_clk);
      chk("rst_strobe", 16'h0, 16'(memory_valid_strobe_q));
      chk("rst_rnw", 16'h1, 16'(read_not_write_q));
      sys_rst = 1'b0;
      t_imm_dir();
      t_dir_store();
      t_idx();
      t_call();
      t_ext();
      t_irq();
      final_report();
   end
endmodule
